// ### rtl/acrb_regs.sv
// Page-zero control registers of the amplifier: page, reset, mode,
// boost/gain, fault status, power and mutes.
// Assumes a register access port driven by the control-bus slave on clk.
//
// Contract
// - An 8-bit page selector, reset 0, picks the page of later accesses.
// - Writing 1 to reset bit 0 starts a self-clearing soft reset; 0 does nothing.
// - Mode bit 7 at 0 enables page auto increment.
// - The 3-bit processing mode, reset 1, selects PCM/PDM playback and sense.
// - Boost bit 0 selects multi-level class-H boost that tracks the signal.
// - Boost bit 1, the reset value, selects class-G boost to maximum voltage.
// - The 4-bit DAC gain sets 0 to 15 dB in 1 dB steps, reset 15.
// - The fault flag reads 1 once an error is detected, reset 0.
// - The 2-bit power state: 0 down, 1 up with boost, 2 up without, reset 0.
// - Power bits 2, 1, 0 mute current sense, voltage sense and audio.
`timescale 1ns/1ps
module acrb_regs #(
   parameter int ADDR_W = 8
) (
   input  logic                   clk,
   input  logic                   nrst,
   input  logic                   regWrEn,
   input  logic                   regRdEn,
   input  logic [ADDR_W-1:0]      regAddr,
   input  logic [7:0]             regWrData,
   output logic [7:0]             regRdData,
   input  logic                   faultDetect,
   output logic [7:0]             pageSelect,
   output logic                   softResetPulse,
   output acrb_pkg::acrb_ctrl_type ctrl
);
   if (ADDR_W != 8) begin : g_addr_check
      $error("acrb_regs needs ADDR_W of 8");
   end

   logic [7:0] page_reg;
   logic       srst_reg;
   logic [7:0] mode_reg;
   logic [7:0] spk_reg;
   logic [7:0] pwr2_reg;
   logic [7:0] pwr1_reg;
   logic [7:0] rd_reg;
   logic [7:0] rd_next;
   logic       onPage0;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // Page register stays reachable on every page so software can return
   assign onPage0 = (page_reg == 8'h00);

   always_ff @(posedge clk) begin
      if (!nrst || srst_reg) begin
         page_reg <= acrb_pkg::RST_PAGE;
      end else if (regWrEn && hit(regAddr, acrb_pkg::OFF_PAGE)) begin
         page_reg <= regWrData;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || srst_reg) begin
         srst_reg <= 1'h0;
      end else begin
         srst_reg <= regWrEn && onPage0 && hit(regAddr, acrb_pkg::OFF_SRST)
                     && regWrData[acrb_pkg::BIT_SRST];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || srst_reg) begin
         mode_reg <= acrb_pkg::RST_MODE;
      end else if (regWrEn && onPage0 && hit(regAddr, acrb_pkg::OFF_MODE)) begin
         mode_reg <= regWrData;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || srst_reg) begin
         spk_reg <= acrb_pkg::RST_SPK;
      end else if (regWrEn && onPage0 && hit(regAddr, acrb_pkg::OFF_SPK)) begin
         spk_reg <= regWrData;
      end
   end

   // Fault flag: a fault in the same cycle as a clearing write wins
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pwr2_reg <= acrb_pkg::RST_PWR2;
      end else begin
         if (srst_reg) begin
            pwr2_reg <= acrb_pkg::RST_PWR2;
         end else if (regWrEn && onPage0 && hit(regAddr, acrb_pkg::OFF_PWR2)) begin
            pwr2_reg <= regWrData;
         end
         if (faultDetect) begin
            pwr2_reg[acrb_pkg::BIT_FAULT] <= 1'h1;
         end
      end
   end

   // Fault power-down overrides a simultaneous power-up write
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pwr1_reg <= acrb_pkg::RST_PWR1;
      end else begin
         if (srst_reg) begin
            pwr1_reg <= acrb_pkg::RST_PWR1;
         end else if (regWrEn && onPage0 && hit(regAddr, acrb_pkg::OFF_PWR1)) begin
            pwr1_reg <= regWrData;
         end
         if (faultDetect) begin
            pwr1_reg[7:6] <= acrb_pkg::PWR_DOWN;
         end
      end
   end

   // Other pages, apart from the page register at offset 0, and unmapped offsets read as zero
   always_comb begin
      rd_next = 8'h00;
      if (hit(regAddr, acrb_pkg::OFF_PAGE)) begin
         rd_next = page_reg;
      end else if (onPage0) begin
         case (regAddr)
            acrb_pkg::OFF_SRST: rd_next = {7'h00, srst_reg};
            acrb_pkg::OFF_MODE: rd_next = mode_reg;
            acrb_pkg::OFF_SPK:  rd_next = spk_reg;
            acrb_pkg::OFF_PWR2: rd_next = pwr2_reg;
            acrb_pkg::OFF_PWR1: rd_next = pwr1_reg;
            default:            rd_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rd_reg <= 8'h00;
      end else if (regRdEn) begin
         rd_reg <= rd_next;
      end
   end

   assign regRdData      = rd_reg;
   assign pageSelect     = page_reg;
   assign softResetPulse = srst_reg;

   always_comb begin
      ctrl.pageAutoIncrement = !mode_reg[acrb_pkg::BIT_PAGE_INC];
      ctrl.processingMode    = mode_reg[2:0];
      ctrl.boostSchemeSelect = spk_reg[acrb_pkg::BIT_BOOST];
      ctrl.dacGain           = spk_reg[3:0];
      ctrl.powerState        = pwr1_reg[7:6];
      ctrl.currentSenseMute  = pwr1_reg[acrb_pkg::BIT_ISNS_MUTE];
      ctrl.voltageSenseMute  = pwr1_reg[acrb_pkg::BIT_VSNS_MUTE];
      ctrl.audioMute         = pwr1_reg[acrb_pkg::BIT_AUD_MUTE];
      // Boost runs only in the powered-with-boost state
      ctrl.boostClassH = (pwr1_reg[7:6] == acrb_pkg::PWR_UP_BOOST)
                         && !spk_reg[acrb_pkg::BIT_BOOST];
      ctrl.boostClassG = (pwr1_reg[7:6] == acrb_pkg::PWR_UP_BOOST)
                         && spk_reg[acrb_pkg::BIT_BOOST];
   end

   property p_page_write;
      @(posedge clk) disable iff (!nrst)
      (regWrEn && regAddr == 8'h00 && !srst_reg) |=> pageSelect == $past(regWrData);
   endproperty
   a_page_write: assert property (p_page_write) else $error("page write lost");

   property p_srst_clears;
      @(posedge clk) disable iff (!nrst)
      softResetPulse |=> !softResetPulse;
   endproperty
   a_srst_clears: assert property (p_srst_clears) else $error("reset bit stuck");

   property p_page_inc;
      @(posedge clk) disable iff (!nrst)
      regWrEn && onPage0 && regAddr == 8'h02 && !srst_reg
      |=> ctrl.pageAutoIncrement == !$past(regWrData[7]);
   endproperty
   a_page_inc: assert property (p_page_inc) else $error("page increment wrong");

   property p_reset_vals;
      @(posedge clk)
      !nrst |=> ctrl.processingMode == 3'h1 && ctrl.dacGain == 4'hF
                && ctrl.boostSchemeSelect && ctrl.powerState == 2'h0;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

   property p_class_h;
      @(posedge clk) disable iff (!nrst)
      regWrEn && onPage0 && regAddr == 8'h04 && !srst_reg && !regWrData[4]
      && ctrl.powerState == 2'h1 && !faultDetect |=> ctrl.boostClassH;
   endproperty
   a_class_h: assert property (p_class_h) else $error("class H wrong");

   property p_class_g;
      @(posedge clk) disable iff (!nrst)
      regWrEn && onPage0 && regAddr == 8'h04 && !srst_reg && regWrData[4]
      && ctrl.powerState == 2'h1 && !faultDetect |=> ctrl.boostClassG;
   endproperty
   a_class_g: assert property (p_class_g) else $error("class G wrong");

   property p_gain;
      @(posedge clk) disable iff (!nrst)
      regWrEn && onPage0 && regAddr == 8'h04 && !srst_reg
      |=> ctrl.dacGain == $past(regWrData[3:0]);
   endproperty
   a_gain: assert property (p_gain) else $error("gain not taken");

   property p_fault_read;
      @(posedge clk) disable iff (!nrst)
      faultDetect ##1 (regRdEn && onPage0 && regAddr == 8'h05 && !srst_reg)
      |=> regRdData[0];
   endproperty
   a_fault_read: assert property (p_fault_read) else $error("fault not read");

   property p_fault_down;
      @(posedge clk) disable iff (!nrst)
      faultDetect |=> ctrl.powerState == 2'h0;
   endproperty
   a_fault_down: assert property (p_fault_down) else $error("fault kept power");

   property p_pwr_write;
      @(posedge clk) disable iff (!nrst)
      regWrEn && onPage0 && regAddr == 8'h07 && !srst_reg && !faultDetect
      |=> ctrl.powerState == $past(regWrData[7:6]) && ctrl.audioMute == $past(regWrData[0]);
   endproperty
   a_pwr_write: assert property (p_pwr_write) else $error("power write lost");

   property p_mute;
      @(posedge clk) disable iff (!nrst)
      regWrEn && onPage0 && regAddr == 8'h07 && !srst_reg
      |=> {ctrl.currentSenseMute, ctrl.voltageSenseMute, ctrl.audioMute}
          == $past(regWrData[2:0]);
   endproperty
   a_mute: assert property (p_mute) else $error("mute mismatch");

   property p_srst_all;
      @(posedge clk) disable iff (!nrst)
      softResetPulse |=> pageSelect == 8'h00 && ctrl.processingMode == 3'h1
                         && ctrl.dacGain == 4'hF
                         && ctrl.boostSchemeSelect && ctrl.powerState == 2'h0;
   endproperty
   a_srst_all: assert property (p_srst_all) else $error("soft reset incomplete");

   // Port-level checks: each except p_fault_hold, which watches the internal fault bit, reacts to a bus event rather than restating a decode
   property p_srst_read;
      @(posedge clk) disable iff (!nrst)
      regRdEn && onPage0 && regAddr == 8'h01 |=> regRdData[7:1] == 7'h00;
   endproperty
   a_srst_read: assert property (p_srst_read) else $error("reset bits 7 to 1 not zero");

   property p_page_hide;
      @(posedge clk) disable iff (!nrst)
      regRdEn && !onPage0 && regAddr != 8'h00 |=> regRdData == 8'h00;
   endproperty
   a_page_hide: assert property (p_page_hide) else $error("other page not hidden");

   property p_page_read;
      @(posedge clk) disable iff (!nrst)
      regRdEn && regAddr == 8'h00 |=> regRdData == $past(pageSelect);
   endproperty
   a_page_read: assert property (p_page_read) else $error("page read wrong");

   property p_hidden_write;
      @(posedge clk) disable iff (!nrst)
      regWrEn && !onPage0 && regAddr == 8'h04 && !srst_reg |=> $stable(ctrl.dacGain);
   endproperty
   a_hidden_write: assert property (p_hidden_write) else $error("hidden write landed");

   property p_fault_hold;
      @(posedge clk) disable iff (!nrst)
      pwr2_reg[acrb_pkg::BIT_FAULT] && !srst_reg
      && !(regWrEn && onPage0 && regAddr == 8'h05) |=> pwr2_reg[acrb_pkg::BIT_FAULT];
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault flag dropped");

   property p_cov_srst;
      @(posedge clk) disable iff (!nrst) softResetPulse;
   endproperty
   c_srst: cover property (p_cov_srst);

   property p_cov_fault;
      @(posedge clk) disable iff (!nrst) ctrl.boostClassG ##1 faultDetect;
   endproperty
   c_fault: cover property (p_cov_fault);

   property p_cov_page;
      @(posedge clk) disable iff (!nrst) !onPage0 && regRdEn;
   endproperty
   c_page: cover property (p_cov_page);

   property p_cov_class_h;
      @(posedge clk) disable iff (!nrst) ctrl.boostClassH;
   endproperty
   c_class_h: cover property (p_cov_class_h);

   property p_cov_pdm;
      @(posedge clk) disable iff (!nrst) ctrl.processingMode == 3'h5;
   endproperty
   c_pdm: cover property (p_cov_pdm);
endmodule : acrb_regs

// ### rtl/acrb_pkg.sv
// Package for the amplifier control register bank, page zero.
// Assumes an 8-bit register address and 8-bit data.
package acrb_pkg;
   localparam logic [7:0] OFF_PAGE  = 8'h00;
   localparam logic [7:0] OFF_SRST  = 8'h01;
   localparam logic [7:0] OFF_MODE  = 8'h02;
   localparam logic [7:0] OFF_SPK   = 8'h04;
   localparam logic [7:0] OFF_PWR2  = 8'h05;
   localparam logic [7:0] OFF_PWR1  = 8'h07;
   localparam logic [7:0] RST_PAGE  = 8'h00;
   localparam logic [7:0] RST_MODE  = 8'h01;
   localparam logic [7:0] RST_SPK   = 8'h5F;
   localparam logic [7:0] RST_PWR2  = 8'h00;
   localparam logic [7:0] RST_PWR1  = 8'h00;
   localparam int BIT_SRST      = 0;
   localparam int BIT_PAGE_INC  = 7;
   localparam int BIT_BOOST     = 4;
   localparam int BIT_FAULT     = 0;
   localparam int BIT_ISNS_MUTE = 2;
   localparam int BIT_VSNS_MUTE = 1;
   localparam int BIT_AUD_MUTE  = 0;
   localparam logic [1:0] PWR_DOWN     = 2'h0;
   localparam logic [1:0] PWR_UP_BOOST = 2'h1;
   localparam logic [1:0] PWR_UP_NOBST = 2'h2;

   typedef struct packed {
      logic       pageAutoIncrement;
      logic [2:0] processingMode;
      logic       boostSchemeSelect;
      logic [3:0] dacGain;
      logic [1:0] powerState;
      logic       currentSenseMute;
      logic       voltageSenseMute;
      logic       audioMute;
      logic       boostClassH;
      logic       boostClassG;
   } acrb_ctrl_type;
endpackage : acrb_pkg

// ### sim/acrb_host.sv
// Host model for the register port: single-byte writes and reads.
// Assumes strobes are taken on rising clk and read data lands one edge later.
`timescale 1ns/1ps
module acrb_host (
   input  logic       clk,
   output logic       regWrEn,
   output logic       regRdEn,
   output logic [7:0] regAddr,
   output logic [7:0] regWrData,
   input  logic [7:0] regRdData
);
   initial begin
      regWrEn   = 1'h0;
      regRdEn   = 1'h0;
      regAddr   = 8'h00;
      regWrData = 8'h00;
   end
   // Released lines show the inverse so a stale value never looks valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regWrEn   <= 1'h1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge clk);
      regWrEn   <= 1'h0;
      regAddr   <= ~a;
      regWrData <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      regRdEn <= 1'h1;
      regAddr <= a;
      @(posedge clk);
      regRdEn <= 1'h0;
      regAddr <= ~a;
      #1;
      d = regRdData;
   endtask : rd
endmodule : acrb_host

// ### sim/tb_amp_control_register_bank.sv
// Self-checking bench for the page-zero register bank against an int model.
// Assumes the host model drives the register port; fault input from here.
`timescale 1ns/1ps
module tb_amp_control_register_bank;
   logic                    clk, nrst, faultDetect, regWrEn, regRdEn, softResetPulse;
   logic [7:0]              regAddr, regWrData, regRdData, pageSelect, got;
   logic [31:0]             v;
   acrb_pkg::acrb_ctrl_type ctrl;
   int                      bad_count, compares, i, a;
   int                      m[8];
   acrb_host host (.clk(clk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
      .regWrData(regWrData), .regRdData(regRdData));
   acrb_regs dut (.clk(clk), .nrst(nrst), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .faultDetect(faultDetect), .pageSelect(pageSelect),
      .softResetPulse(softResetPulse), .ctrl(ctrl));
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic model_reset;
      m = '{0, 0, 1, 0, 'h5f, 0, 0, 0};
   endtask : model_reset
   // Page-zero offsets other than the page register at offset 0 are hidden whenever another page is selected
   task automatic rdChk(input int ad);
      logic [7:0] e;
      e = (ad == 0) ? m[0][7:0] : (m[0] != 0 || ad > 7) ? 8'h00 : m[ad][7:0];
      host.rd(8'(ad), got);
      chk("regRdData", {16'h0000, e}, {16'h0000, got});
   endtask : rdChk
   task automatic ctlChk;
      logic [7:0] md, sp, pw;
      // Let the edge that launched the last write settle first
      #1;
      md = m[2][7:0];
      sp = m[4][7:0];
      pw = m[7][7:0];
      chk("ctrl", {m[0][7:0], ~md[7], md[2:0], sp[4:0], pw[7:6], pw[2:0],
         pw[7:6] == 2'h1 && !sp[4], pw[7:6] == 2'h1 && sp[4]}, {pageSelect, ctrl});
   endtask : ctlChk
   task automatic complete_run;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run
   initial begin
      #2000000;
      bad_count++;
      complete_run();
   end
   initial begin
      nrst        = 1'h0;
      faultDetect = 1'h0;
      v           = 32'h3c6d_2f54;
      repeat (10) @(posedge clk);
      nrst <= 1'h1;
      model_reset();
      for (a = 0; a < 9; a++) rdChk(a);
      ctlChk();
      // Every mode and power code, random other bits
      for (i = 0; i < 16; i++) begin
         v = lfsr(v);
         m[2] = {v[7:3], 3'(i)};
         m[4] = v[15:8];
         m[7] = {2'(i), v[21:16]};
         m[5] = v[31:24];
         host.wr(8'h02, m[2][7:0]);
         host.wr(8'h04, m[4][7:0]);
         host.wr(8'h07, m[7][7:0]);
         host.wr(8'h05, m[5][7:0]);
         host.wr(8'h03, v[7:0]);
         ctlChk();
         foreach (m[a]) rdChk(a);
      end
      host.wr(8'h00, 8'h01);
      m[0] = 1;
      host.wr(8'h04, 8'h00);
      for (a = 0; a < 8; a++) rdChk(a);
      host.wr(8'h00, 8'h00);
      m[0] = 0;
      rdChk(4);
      host.wr(8'h07, 8'h45);
      // Fault lands one edge before the flag read is taken
      m[5] = m[5] | 1;
      m[7] = 'h45 & 'h3f;
      fork
         rdChk(5);
         begin
            faultDetect <= 1'h1;
            @(posedge clk);
            faultDetect <= 1'h0;
         end
      join
      ctlChk();
      rdChk(7);
      host.wr(8'h05, 8'h00);
      m[5] = 0;
      rdChk(5);
      host.wr(8'h01, 8'h00);
      rdChk(1);
      ctlChk();
      host.wr(8'h01, 8'h01);
      #1;
      chk("softResetPulse", 24'h00_0001, {23'h0, softResetPulse});
      @(posedge clk);
      #1;
      chk("softResetPulse", 24'h00_0000, {23'h0, softResetPulse});
      model_reset();
      ctlChk();
      foreach (m[a]) rdChk(a);
      complete_run();
   end
endmodule : tb_amp_control_register_bank
